// >>> hw/hub_cfg_pkg.sv
/*
  Shared constants and types for the hub option byte decoder: byte offsets,
  field positions, default values, overcurrent delay times and the packed
  settings carrier.
  Assumes a 100 MHz core clock; all cycle counts are derived from it.
*/
package hub_cfg_pkg;

  // ****************************************************************
  // Clock
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;

  // ****************************************************************
  // Byte offsets within the configuration image
  // ****************************************************************
  localparam logic [3:0] OFS_OPTION_ONE = 4'h6;
  localparam logic [3:0] OFS_OPTION_TWO = 4'h7;
  localparam logic [3:0] OFS_FIXED_PORTS = 4'h8;
  localparam logic [3:0] OFS_SELF_OFF = 4'h9;
  localparam logic [3:0] OFS_BUS_OFF = 4'hA;
  localparam int NUM_BYTES = 5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_POWER_SOURCE = 7;
  localparam int BIT_LED_SUPPORT = 6;
  localparam int BIT_HS_INHIBIT = 5;
  localparam int BIT_PER_PORT_TT = 4;
  localparam int BIT_EOP_SUPPRESS = 3;
  localparam int BIT_OC_MODE_LO = 1;
  localparam int BIT_PORT_POWER = 0;
  localparam int BIT_DYNAMIC = 7;
  localparam int BIT_OC_DELAY_LO = 4;
  localparam int BIT_COMPOUND = 3;
  localparam int BIT_PORT_LO = 1;
  localparam int NUM_PORTS = 4;

  // ****************************************************************
  // Default values and writable-bit masks
  // ****************************************************************
  localparam logic [7:0] RST_OPTION_ONE_SELF = 8'h98;
  localparam logic [7:0] RST_OPTION_ONE_BUS = 8'h1C;
  localparam logic [7:0] RST_OPTION_TWO = 8'h90;
  localparam logic [7:0] RST_PORT_BYTE = 8'h00;
  localparam logic [7:0] MASK_OPTION_ONE = 8'hFF;
  localparam logic [7:0] MASK_OPTION_TWO = 8'hB8;
  localparam logic [7:0] MASK_PORT_BYTE = 8'h1E;

  // ****************************************************************
  // Overcurrent filter delay (times in microseconds)
  // ****************************************************************
  localparam int OC_DELAY_T0_US = 100;
  localparam int OC_DELAY_T1_US = 2000;
  localparam int OC_DELAY_T2_US = 4000;
  localparam int OC_DELAY_T3_US = 6000;
  localparam int OC_DELAY_C0 = OC_DELAY_T0_US * 1000 / CLK_PERIOD_NS;
  localparam int OC_DELAY_C1 = OC_DELAY_T1_US * 1000 / CLK_PERIOD_NS;
  localparam int OC_DELAY_C2 = OC_DELAY_T2_US * 1000 / CLK_PERIOD_NS;
  localparam int OC_DELAY_C3 = OC_DELAY_T3_US * 1000 / CLK_PERIOD_NS;
  localparam int OC_COUNT_W = 20;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {OC_GANGED, OC_PER_PORT, OC_NONE} oc_sense_e;

  typedef struct packed {
    logic selfPowered;
    logic ledIndicatorSupport;
    logic highSpeedInhibit;
    logic perPortTranslatorEnable;
    logic frameEndEopSuppress;
    oc_sense_e overcurrentSenseMode;
    logic portPowerSwitchMode;
    logic dynamicPowerEnable;
    logic compoundDevice;
    logic [3:0] fixedDevicePortMask;
    logic [3:0] portOffMask;
  } hub_settings_s;

endpackage : hub_cfg_pkg

// >>> hw/power_source_arbiter.sv
/*
  Chooses between self and bus power for the hub.
  Assumes the local power detect pin is synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module power_source_arbiter (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Configuration
  input wire logic dynamicEnable,
  input wire logic configSelf,
  // Pin
  input wire logic localPowerDetect,
  // Result
  output logic selfPowered_reg
);

  // ****************************************************************
  // Source selection
  // ****************************************************************
  // Dynamic mode follows the pin both ways, so losing local supply drops
  // to bus power and restoring it returns to self power
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      selfPowered_reg <= 1'b0;
    end else if (dynamicEnable) begin
      selfPowered_reg <= localPowerDetect;
    end else begin
      selfPowered_reg <= configSelf;
    end
  end

endmodule : power_source_arbiter
`default_nettype wire

// >>> hw/oc_delay_select.sv
/*
  Turns the two-bit overcurrent timer code into a filter length in cycles.
  Assumes the code is stable apart from configuration writes.
*/
`timescale 1ns/1ps
`default_nettype none
module oc_delay_select #(
  parameter int COUNT_W = hub_cfg_pkg::OC_COUNT_W,
  parameter int DELAY0 = hub_cfg_pkg::OC_DELAY_C0,
  parameter int DELAY1 = hub_cfg_pkg::OC_DELAY_C1,
  parameter int DELAY2 = hub_cfg_pkg::OC_DELAY_C2,
  parameter int DELAY3 = hub_cfg_pkg::OC_DELAY_C3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Code
  input wire logic [1:0] delayCode,
  // Result
  output logic [COUNT_W-1:0] delayCycles_reg
);

  // ****************************************************************
  // Lookup
  // ****************************************************************
  function automatic logic [COUNT_W-1:0] codeToCycles(input logic [1:0] code);
    logic [COUNT_W-1:0] c;
    c = COUNT_W'(DELAY1);
    unique case (code)
      2'h0: c = COUNT_W'(DELAY0);
      2'h1: c = COUNT_W'(DELAY1);
      2'h2: c = COUNT_W'(DELAY2);
      2'h3: c = COUNT_W'(DELAY3);
    endcase
    return c;
  endfunction : codeToCycles

  // Registered so the long constants do not sit on a timing path
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      delayCycles_reg <= COUNT_W'(DELAY1);
    end else begin
      delayCycles_reg <= codeToCycles(delayCode);
    end
  end

endmodule : oc_delay_select
`default_nettype wire

// >>> hw/hub_option_config_decode.sv
/*
  Holds the hub option bytes at offsets 6h to Ah and decodes them into the
  settings that the hub engine consumes; gates upstream attach until the
  image has been loaded.
  Assumes the byte source (configuration memory reader or SMBus slave)
  presents one-cycle write strobes synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module hub_option_config_decode #(
  parameter int OC_DELAY0 = hub_cfg_pkg::OC_DELAY_C0,
  parameter int OC_DELAY1 = hub_cfg_pkg::OC_DELAY_C1,
  parameter int OC_DELAY2 = hub_cfg_pkg::OC_DELAY_C2,
  parameter int OC_DELAY3 = hub_cfg_pkg::OC_DELAY_C3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Configuration byte port
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [3:0] cfgAddr,
  input wire logic [7:0] cfgWriteData,
  input wire logic cfgLoadDone,
  output logic [7:0] cfgReadData_reg,
  // Straps and pins
  input wire logic strapSelfDefault,
  input wire logic strapExternalConfig,
  input wire logic localPowerDetect,
  // Decoded settings
  output hub_cfg_pkg::hub_settings_s settings_reg,
  output logic [hub_cfg_pkg::OC_COUNT_W-1:0] overcurrentFilterCycles_reg,
  output logic attachEnable_reg,
  output logic configConflict_reg
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [1:0] {ST_STRAP, ST_LOAD, ST_RUN} load_state_e;

  load_state_e state_reg;
  logic [7:0] cfgBytes_reg [hub_cfg_pkg::NUM_BYTES];
  logic selfPowered;
  logic [7:0] optOne;
  logic [7:0] optTwo;
  logic [3:0] selfOffMask;
  logic [3:0] busOffMask;
  logic writeHit;
  logic [2:0] writeIndex;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Offset to storage index; out-of-range offsets miss
  function automatic logic [2:0] byteIndex(input logic [3:0] addr);
    return 3'(addr - hub_cfg_pkg::OFS_OPTION_ONE);
  endfunction : byteIndex

  function automatic logic byteHit(input logic [3:0] addr);
    return (addr >= hub_cfg_pkg::OFS_OPTION_ONE) && (addr <= hub_cfg_pkg::OFS_BUS_OFF);
  endfunction : byteHit

  // Reserved bits are stored as zero so they cannot reach any decode
  function automatic logic [7:0] writeMask(input logic [2:0] idx);
    logic [7:0] m;
    m = hub_cfg_pkg::MASK_PORT_BYTE;
    if (idx == 3'h0) begin
      m = hub_cfg_pkg::MASK_OPTION_ONE;
    end else if (idx == 3'h1) begin
      m = hub_cfg_pkg::MASK_OPTION_TWO;
    end
    return m;
  endfunction : writeMask

  function automatic hub_cfg_pkg::oc_sense_e senseDecode(input logic [1:0] code);
    hub_cfg_pkg::oc_sense_e s;
    s = hub_cfg_pkg::OC_NONE;
    if (code == 2'h0) begin
      s = hub_cfg_pkg::OC_GANGED;
    end else if (code == 2'h1) begin
      s = hub_cfg_pkg::OC_PER_PORT;
    end
    return s;
  endfunction : senseDecode

  function automatic logic [3:0] portField(input logic [7:0] b);
    return b[hub_cfg_pkg::BIT_PORT_LO +: hub_cfg_pkg::NUM_PORTS];
  endfunction : portField

  // Contiguous when the mask plus its lowest set bit is a power of two
  function automatic logic isContiguous(input logic [3:0] m);
    logic [4:0] sum;
    sum = {1'b0, m} + {1'b0, m & (~m + 4'h1)};
    return (sum & (sum - 5'h01)) == 5'h00;
  endfunction : isContiguous

  // ****************************************************************
  // Field views
  // ****************************************************************
  assign optOne = cfgBytes_reg[0];
  assign optTwo = cfgBytes_reg[1];
  assign selfOffMask = portField(cfgBytes_reg[3]);
  assign busOffMask = portField(cfgBytes_reg[4]);
  assign writeHit = cfgWrite && byteHit(cfgAddr) && (state_reg != ST_STRAP);
  assign writeIndex = byteIndex(cfgAddr);

  // ****************************************************************
  // Load sequencing
  // ****************************************************************
  // Straps are caught in the first cycle after release, never by reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_STRAP;
    end else begin
      unique case (state_reg)
        ST_STRAP: state_reg <= strapExternalConfig ? ST_LOAD : ST_RUN;
        ST_LOAD: begin
          if (cfgLoadDone) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: state_reg <= ST_RUN;
      endcase
    end
  end

  // Attach only once the image is complete
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      attachEnable_reg <= 1'b0;
    end else begin
      attachEnable_reg <= (state_reg == ST_RUN);
    end
  end

  // ****************************************************************
  // Byte storage
  // ****************************************************************
  // Option one default follows the power strap; later writes overwrite the defaults
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfgBytes_reg[0] <= hub_cfg_pkg::RST_OPTION_ONE_SELF;
      cfgBytes_reg[1] <= hub_cfg_pkg::RST_OPTION_TWO;
      cfgBytes_reg[2] <= hub_cfg_pkg::RST_PORT_BYTE;
      cfgBytes_reg[3] <= hub_cfg_pkg::RST_PORT_BYTE;
      cfgBytes_reg[4] <= hub_cfg_pkg::RST_PORT_BYTE;
    end else if (state_reg == ST_STRAP) begin
      cfgBytes_reg[0] <= strapSelfDefault ? hub_cfg_pkg::RST_OPTION_ONE_SELF
                                          : hub_cfg_pkg::RST_OPTION_ONE_BUS;
    end else if (writeHit) begin
      cfgBytes_reg[writeIndex] <= cfgWriteData & writeMask(writeIndex);
    end
  end

  // Read-back shows stored bytes; unmapped offsets read zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfgReadData_reg <= 8'h00;
    end else if (cfgRead) begin
      cfgReadData_reg <= byteHit(cfgAddr) ? cfgBytes_reg[byteIndex(cfgAddr)] : 8'h00;
    end
  end

  // ****************************************************************
  // Power source and overcurrent delay
  // ****************************************************************
  power_source_arbiter u_power (
    .mclk(mclk),
    .reset_n(reset_n),
    .dynamicEnable(optTwo[hub_cfg_pkg::BIT_DYNAMIC]),
    .configSelf(optOne[hub_cfg_pkg::BIT_POWER_SOURCE]),
    .localPowerDetect(localPowerDetect),
    .selfPowered_reg(selfPowered)
  );

  oc_delay_select #(
    .COUNT_W(hub_cfg_pkg::OC_COUNT_W),
    .DELAY0(OC_DELAY0),
    .DELAY1(OC_DELAY1),
    .DELAY2(OC_DELAY2),
    .DELAY3(OC_DELAY3)
  ) u_ocdelay (
    .mclk(mclk),
    .reset_n(reset_n),
    .delayCode(optTwo[hub_cfg_pkg::BIT_OC_DELAY_LO +: 2]),
    .delayCycles_reg(overcurrentFilterCycles_reg)
  );

  // ****************************************************************
  // Settings decode
  // ****************************************************************
  // One register stage; every field moves one cycle after its byte, except selfPowered and the portOffMask choice, which take two through the arbiter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      settings_reg <= '0;
    end else begin
      settings_reg.selfPowered <= selfPowered;
      settings_reg.ledIndicatorSupport <= optOne[hub_cfg_pkg::BIT_LED_SUPPORT];
      settings_reg.highSpeedInhibit <= optOne[hub_cfg_pkg::BIT_HS_INHIBIT];
      settings_reg.perPortTranslatorEnable <= optOne[hub_cfg_pkg::BIT_PER_PORT_TT];
      settings_reg.frameEndEopSuppress <= optOne[hub_cfg_pkg::BIT_EOP_SUPPRESS];
      settings_reg.overcurrentSenseMode <=
        senseDecode(optOne[hub_cfg_pkg::BIT_OC_MODE_LO +: 2]);
      settings_reg.portPowerSwitchMode <= optOne[hub_cfg_pkg::BIT_PORT_POWER];
      settings_reg.dynamicPowerEnable <= optTwo[hub_cfg_pkg::BIT_DYNAMIC];
      settings_reg.compoundDevice <= optTwo[hub_cfg_pkg::BIT_COMPOUND];
      settings_reg.fixedDevicePortMask <= portField(cfgBytes_reg[2]);
      settings_reg.portOffMask <= selfPowered ? selfOffMask : busOffMask;
    end
  end

  // Flags source mistakes the hub tolerates but should not see
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      configConflict_reg <= 1'b0;
    end else begin
      configConflict_reg <= (selfPowered && optOne[hub_cfg_pkg::BIT_OC_MODE_LO + 1])
                            || !isContiguous(selfOffMask)
                            || !isContiguous(busOffMask);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_power_static;
    @(posedge mclk) disable iff (!reset_n)
    (!optTwo[hub_cfg_pkg::BIT_DYNAMIC] && $stable(optTwo) && $stable(optOne))
      |=> ##1 settings_reg.selfPowered == $past(optOne[hub_cfg_pkg::BIT_POWER_SOURCE], 2);
  endproperty
  a_power_static: assert property (p_power_static) else $error("static power source wrong");

  property p_power_dynamic;
    @(posedge mclk) disable iff (!reset_n)
    optTwo[hub_cfg_pkg::BIT_DYNAMIC] |-> ##2
      settings_reg.selfPowered == $past(localPowerDetect, 2) || !$past(optTwo[7], 1);
  endproperty
  a_power_dynamic: assert property (p_power_dynamic) else $error("dynamic power ignores pin");

  property p_speed_inhibit;
    @(posedge mclk) disable iff (!reset_n)
    ##1 settings_reg.highSpeedInhibit == $past(optOne[hub_cfg_pkg::BIT_HS_INHIBIT]);
  endproperty
  a_speed_inhibit: assert property (p_speed_inhibit) else $error("speed inhibit wrong");

  property p_led_tt_eop;
    @(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) or 1'b1 |=> {settings_reg.ledIndicatorSupport,
      settings_reg.perPortTranslatorEnable, settings_reg.frameEndEopSuppress}
      == $past({optOne[6], optOne[4], optOne[3]});
  endproperty
  a_led_tt_eop: assert property (p_led_tt_eop) else $error("option one flags wrong");

  property p_sense_none;
    @(posedge mclk) disable iff (!reset_n)
    optOne[2] |=> settings_reg.overcurrentSenseMode == hub_cfg_pkg::OC_NONE;
  endproperty
  a_sense_none: assert property (p_sense_none) else $error("sense mode not none");

  property p_sense_ports;
    @(posedge mclk) disable iff (!reset_n)
    (optOne[2:1] == 2'h1) |=> settings_reg.overcurrentSenseMode == hub_cfg_pkg::OC_PER_PORT;
  endproperty
  a_sense_ports: assert property (p_sense_ports) else $error("sense mode not per port");

  property p_delay_default;
    @(posedge mclk) disable iff (!reset_n)
    (optTwo[5:4] == 2'h1) [*2] |-> overcurrentFilterCycles_reg == OC_DELAY1;
  endproperty
  a_delay_default: assert property (p_delay_default) else $error("default delay wrong");

  property p_port_select;
    @(posedge mclk) disable iff (!reset_n)
    !selfPowered |=> settings_reg.portOffMask == $past(busOffMask);
  endproperty
  a_port_select: assert property (p_port_select) else $error("bus mask not used");

  property p_self_mask;
    @(posedge mclk) disable iff (!reset_n)
    selfPowered |=> settings_reg.portOffMask == $past(selfOffMask)
      && settings_reg.fixedDevicePortMask == $past(portField(cfgBytes_reg[2]));
  endproperty
  a_self_mask: assert property (p_self_mask) else $error("self mask or fixed ports wrong");

  property p_no_early_attach;
    @(posedge mclk) disable iff (!reset_n)
    (state_reg == ST_LOAD) |=> !attachEnable_reg;
  endproperty
  a_no_early_attach: assert property (p_no_early_attach) else $error("attach before load");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!reset_n)
    ((optTwo & ~hub_cfg_pkg::MASK_OPTION_TWO) == 8'h00)
      && ((cfgBytes_reg[2] & ~hub_cfg_pkg::MASK_PORT_BYTE) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits stored");

  property p_compound;
    @(posedge mclk) disable iff (!reset_n)
    $rose(optTwo[3]) |=> settings_reg.compoundDevice ##1 settings_reg.compoundDevice || !optTwo[3];
  endproperty
  a_compound: assert property (p_compound) else $error("compound flag lost");

  c_load_attach: cover property (@(posedge mclk) disable iff (!reset_n)
    state_reg == ST_LOAD ##[1:50] attachEnable_reg);
  c_dynamic_drop: cover property (@(posedge mclk) disable iff (!reset_n)
    settings_reg.dynamicPowerEnable && $fell(settings_reg.selfPowered));
  c_conflict: cover property (@(posedge mclk) disable iff (!reset_n) configConflict_reg);

endmodule : hub_option_config_decode
`default_nettype wire

// >>> testbench/cfg_source_model.sv
/*
  Behavioural configuration source: streams the five option bytes into the
  hub byte port, then pulses the load-done strobe.
  Assumes the bench raises start for one cycle and keeps image steady while
  busy is high.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_source_model (
  // Clock
  input wire logic mclk,
  // Bench control
  input wire logic start,
  input wire logic slow,
  input wire logic [39:0] image,
  output logic busy,
  // Byte port
  output logic cfgWrite,
  output logic [3:0] cfgAddr,
  output logic [7:0] cfgWriteData,
  output logic cfgLoadDone
);
  logic [7:0] b;
  int k;

  // Writes launch on the falling edge so the hub samples settled data
  initial begin
    busy = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 4'h0;
    cfgWriteData = 8'h00;
    cfgLoadDone = 1'b0;
    forever begin
      @(posedge mclk);
      if (start) begin
        busy = 1'b1;
        @(negedge mclk);
        for (k = 0; k < 5; k++) begin
          b = image[8*k +: 8];
          if (k >= 2) b = b & 8'h1E;
          if (k == 0 && b[7]) b[2] = 1'b0;
          cfgWrite = 1'b1;
          cfgAddr = 4'h6 + k[3:0];
          cfgWriteData = b;
          @(negedge mclk);
          // Slow source idles between bytes; released lines show junk
          if (slow) begin
            cfgWrite = 1'b0;
            cfgAddr = ~cfgAddr;
            cfgWriteData = ~b;
            repeat (3) @(negedge mclk);
          end
        end
        cfgWrite = 1'b0;
        cfgAddr = ~cfgAddr;
        cfgWriteData = ~b;
        cfgLoadDone = 1'b1;
        @(negedge mclk);
        cfgLoadDone = 1'b0;
        busy = 1'b0;
      end
    end
  end
endmodule : cfg_source_model
`default_nettype wire

// >>> testbench/tb_hub_option_config_decode.sv
/*
  Self-checking bench for the hub option byte decoder.
  Assumes the source model is the only writer; reads share the offset bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_hub_option_config_decode;
  logic mclk, reset_n, cfgRead, localPowerDetect, start, slow, busy;
  logic cfgWrite, cfgLoadDone, attachEnable_reg;
  logic strapSelf, configConflict;
  logic [3:0] cfgAddr, wrAddr, rdAddr;
  logic [7:0] cfgWriteData, cfgReadData_reg;
  logic [39:0] image;
  logic [19:0] overcurrentFilterCycles_reg;
  hub_cfg_pkg::hub_settings_s settings_reg;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  // Offset bus is shared; reads happen only while the source is idle
  assign cfgAddr = cfgRead ? rdAddr : wrAddr;

  // Small filter lengths keep the run short
  hub_option_config_decode #(.OC_DELAY0(10), .OC_DELAY1(20), .OC_DELAY2(40),
    .OC_DELAY3(60)) hub_option_config_decode_inst (.mclk(mclk), .reset_n(reset_n),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgWriteData(cfgWriteData), .cfgLoadDone(cfgLoadDone),
    .cfgReadData_reg(cfgReadData_reg), .strapSelfDefault(strapSelf),
    .strapExternalConfig(1'b1), .localPowerDetect(localPowerDetect),
    .settings_reg(settings_reg), .overcurrentFilterCycles_reg(overcurrentFilterCycles_reg),
    .attachEnable_reg(attachEnable_reg), .configConflict_reg(configConflict));

  cfg_source_model cfg_source_model_inst (.mclk(mclk), .start(start), .slow(slow),
    .image(image), .busy(busy), .cfgWrite(cfgWrite), .cfgAddr(wrAddr),
    .cfgWriteData(cfgWriteData), .cfgLoadDone(cfgLoadDone));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    rdAddr = a;
    cfgRead = 1'b1;
    @(negedge mclk);
    cfgRead = 1'b0;
    @(negedge mclk);
    chk("readData", {24'h0, exp}, {24'h0, cfgReadData_reg});
  endtask : rd

  // Hand an image to the source and wait for it to finish, bounded
  task automatic load(input logic [39:0] img, input logic s);
    int n;
    image = img;
    slow = s;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    for (n = 0; n < 60 && busy; n++) @(negedge mclk);
    repeat (4) @(negedge mclk);
  endtask : load

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Strap defaults with dynamic switching on: pin decides power
  task automatic t_defaults;
    chk("settings", {14'h0, 18'h26200}, {14'h0, settings_reg});
    chk("filter", 32'd20, {12'h0, overcurrentFilterCycles_reg});
    chk("attach", 32'h0, {31'h0, attachEnable_reg});
    rd(4'h6, 8'h98);
    rd(4'h7, 8'h90);
  endtask : t_defaults

  // Slow load gates attach, then the pin moves power both ways
  task automatic t_attach_dynamic;
    load({8'h18, 8'h06, 8'h02, 8'h90, 8'h1C}, 1'b1);
    chk("attach", 32'h1, {31'h0, attachEnable_reg});
    for (int p = 0; p < 3; p++) begin
      localPowerDetect = p[0] ? 1'b0 : 1'b1;
      repeat (4) @(negedge mclk);
      chk("selfPowered", {31'h0, ~p[0]}, {31'h0, settings_reg.selfPowered});
      chk("portOff", p[0] ? 32'hC : 32'h3, {28'h0, settings_reg.portOffMask});
      chk("conflict", {31'h0, ~p[0]}, {31'h0, configConflict});
    end
  endtask : t_attach_dynamic

  // Every sense and delay code, reserved bits set, static power
  task automatic t_fields;
    logic [7:0] b6, b7, b8;
    logic [1:0] sense;
    int dly[4] = '{10, 20, 40, 60};
    for (int i = 0; i < 4; i++) begin
      b6 = {~i[1], i[0], ~i[0], i[1], i[0] ^ i[1], i[1:0], ~i[1]};
      b7 = {1'b0, 1'b1, i[1:0], i[0], 3'b111};
      b8 = {3'b111, i[1:0], ~i[1:0], 1'b1};
      sense = i[1] ? hub_cfg_pkg::OC_NONE : (i[0] ? hub_cfg_pkg::OC_PER_PORT :
        hub_cfg_pkg::OC_GANGED);
      load({8'h18, 8'h06, b8, b7, b6}, 1'b0);
      chk("settings", {14'h0, ~i[1], i[0], ~i[0], i[1], i[0] ^ i[1], sense, ~i[1], 1'b0,
        i[0], i[1:0], ~i[1:0], i[1] ? 4'hC : 4'h3}, {14'h0, settings_reg});
      chk("filter", dly[i], {12'h0, overcurrentFilterCycles_reg});
      chk("conflict", 32'h0, {31'h0, configConflict});
      rd(4'h7, {2'b00, i[1:0], i[0], 3'b000});
      rd(4'h8, {3'b000, i[1:0], ~i[1:0], 1'b0});
    end
    rd(4'h5, 8'h00);
    rd(4'hB, 8'h00);
    rd(4'hA, 8'h18);
  endtask : t_fields

  // Mid-run reset with bus strap: bus defaults load, pin still decides power
  task automatic t_bus_strap;
    strapSelf = 1'b0;
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    repeat (5) @(negedge mclk);
    rd(4'h6, 8'h1C);
    chk("selfPowered", 32'h1, {31'h0, settings_reg.selfPowered});
    chk("senseMode", {30'h0, hub_cfg_pkg::OC_NONE},
      {30'h0, settings_reg.overcurrentSenseMode});
    chk("conflict", 32'h1, {31'h0, configConflict});
    chk("attach", 32'h0, {31'h0, attachEnable_reg});
  endtask : t_bus_strap

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    reset_n = 1'b0;
    cfgRead = 1'b0;
    rdAddr = 4'h0;
    localPowerDetect = 1'b1;
    strapSelf = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    image = 40'h0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    repeat (5) @(negedge mclk);
    t_defaults();
    t_attach_dynamic();
    t_fields();
    t_bus_strap();
    complete_run();
  end
endmodule : tb_hub_option_config_decode
`default_nettype wire
